// ===== hdl/op_sample_event_capture.sv
`timescale 1ns/1ps
`default_nettype none
module op_sample_event_capture
   import op_sample_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Register port
   input  wire logic                  msr_rd,
   input  wire logic                  msr_wr,
   input  wire logic [MSR_IDX_W-1:0]  msr_index,
   input  wire logic [63:0]           msr_wdata,
   output logic [63:0]                msr_rdata,
   output logic                       msr_ack,
   // Decode
   output logic                       tag_request,
   input  wire logic                  op_tagged,
   // Retirement
   input  wire logic                  op_complete,
   input  wire logic                  op_retire,
   input  wire logic                  op_flush,
   input  wire logic                  ret_branch,
   input  wire logic                  ret_mispredict,
   input  wire logic                  ret_taken,
   input  wire logic                  ret_return,
   input  wire logic                  ret_return_misp,
   input  wire logic                  ret_resync,
   // Load/store unit
   input  wire logic                  ls_valid,
   input  wire logic [MEM_FLAG_W-1:0] ls_flags,
   input  wire logic                  ls_phys_direct,
   input  wire logic [63:0]           ls_linear_addr,
   input  wire logic [63:0]           ls_physical_addr,
   input  wire logic                  dc_miss_detect,
   input  wire logic                  dc_data_deliver,
   // Pipeline control and interrupt
   output logic                       kill_younger,
   output logic                       fetch_redirect,
   output logic                       full_flush,
   output logic                       sample_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   sample_state_e         state_reg, state_next;
   logic [SEL_W-1:0]      sel_count_reg, sel_count_next;
   logic [MAX_HI_W-1:0]   max_hi_reg, max_hi_next;
   logic                  enable_reg, enable_next;
   logic                  valid_reg, valid_next;
   logic [SEED_W-1:0]     seed_reg, seed_next;
   logic [BR_FLAG_W-1:0]  br_reg, br_next;
   logic [MEM_FLAG_W-1:0] mem_reg, mem_next;
   logic                  lin_valid_reg, lin_valid_next;
   logic                  phys_valid_reg, phys_valid_next;
   logic [63:0]           lin_addr_reg, lin_addr_next;
   logic [63:0]           phys_addr_reg, phys_addr_next;
   logic                  completed_reg, completed_next;
   logic                  miss_open_reg, miss_open_next;
   logic                  tag_req_reg, tag_req_next;
   logic                  kill_reg, kill_next;
   logic                  redirect_reg, redirect_next;
   logic                  flush_reg, flush_next;
   logic                  irq_reg, irq_next;
   logic [63:0]           rdata_reg, rdata_next;
   logic                  ack_reg, ack_next;

   logic [SEL_W-1:0]      sel_max;
   logic                  take_tag;
   logic                  in_flight;
   logic                  retire_now;
   logic [TALLY_W-1:0]    tag_cycles, comp_cycles, miss_cycles;

   assign sel_max    = {max_hi_reg, 4'h0};
   assign take_tag   = state_reg == SEL_TAG_WAIT && op_tagged;
   assign in_flight  = state_reg == SEL_IN_FLIGHT;
   assign retire_now = in_flight && op_retire;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle counts
   cycle_tally u_tag_to_retire (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clear   (take_tag),
      .run     (in_flight && !op_retire),
      .count   (tag_cycles)
   );

   cycle_tally u_complete_to_retire (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clear   (take_tag),
      .run     (in_flight && completed_reg && !op_retire),
      .count   (comp_cycles)
   );

   cycle_tally u_load_miss_latency (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clear   (take_tag),
      .run     (miss_open_reg),
      .count   (miss_cycles)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_next      = state_reg;
      sel_count_next  = sel_count_reg;
      max_hi_next     = max_hi_reg;
      enable_next     = enable_reg;
      valid_next      = valid_reg;
      seed_next       = {seed_reg[5:0], seed_reg[6] ^ seed_reg[5]};
      br_next         = br_reg;
      mem_next        = mem_reg;
      lin_valid_next  = lin_valid_reg;
      phys_valid_next = phys_valid_reg;
      lin_addr_next   = lin_addr_reg;
      phys_addr_next  = phys_addr_reg;
      completed_next  = completed_reg;
      miss_open_next  = miss_open_reg;
      tag_req_next    = 1'b0;
      kill_next       = 1'b0;
      redirect_next   = 1'b0;
      flush_next      = 1'b0;
      irq_next        = 1'b0;

      unique case (state_reg)
         SEL_COUNT: begin
            if (enable_reg) begin
               if (sel_count_reg == sel_max) begin
                  state_next   = SEL_TAG_WAIT;
                  tag_req_next = 1'b1;
               end else begin
                  sel_count_next = sel_count_reg + 1'b1;
               end
            end
         end
         SEL_TAG_WAIT: begin
            tag_req_next = 1'b1;
            if (op_tagged) begin
               tag_req_next    = 1'b0;
               state_next      = SEL_IN_FLIGHT;
               br_next         = '0;
               mem_next        = '0;
               lin_valid_next  = 1'b0;
               phys_valid_next = 1'b0;
               lin_addr_next   = '0;
               phys_addr_next  = '0;
               completed_next  = 1'b0;
               miss_open_next  = 1'b0;
            end
         end
         SEL_IN_FLIGHT: begin
            if (op_complete) begin
               completed_next = 1'b1;
            end
            if (ls_valid) begin
               mem_next = mem_reg | ls_flags;
               if (ls_flags[MEM_LOAD] || ls_flags[MEM_STORE]) begin
                  phys_valid_next = 1'b1;
                  phys_addr_next  = ls_physical_addr;
                  if (!ls_phys_direct) begin
                     lin_valid_next = 1'b1;
                     lin_addr_next  = ls_linear_addr;
                  end
               end
            end
            if (dc_data_deliver) begin
               miss_open_next = 1'b0;
            end
            if (dc_miss_detect && (mem_reg[MEM_LOAD] || (ls_valid && ls_flags[MEM_LOAD]))) begin
               miss_open_next = 1'b1;
            end
            if (op_flush) begin
               state_next     = SEL_COUNT;
               sel_count_next = {{(SEL_W-SEED_W){1'b0}}, seed_reg};
               miss_open_next = 1'b0;
            end else if (op_retire) begin
               state_next     = SEL_HOLD;
               valid_next     = 1'b1;
               irq_next       = 1'b1;
               miss_open_next = 1'b0;
               br_next[BR_RETIRED] = ret_branch;
               br_next[BR_MISP]    = ret_branch && ret_mispredict;
               br_next[BR_TAKEN]   = ret_branch && ret_taken;
               br_next[BR_RETURN]  = ret_return;
               br_next[BR_RET_MISP] = ret_return && ret_return_misp;
               br_next[BR_RESYNC]  = ret_resync;
               if (ret_resync) begin
                  flush_next    = 1'b1;
                  redirect_next = 1'b1;
               end else if (ret_branch && ret_mispredict) begin
                  kill_next     = 1'b1;
                  redirect_next = 1'b1;
               end
            end
         end
         SEL_HOLD: begin
            if (!valid_reg) begin
               state_next     = SEL_COUNT;
               sel_count_next = '0;
            end
         end
      endcase

      // Software writes: clearing the valid bit re-arms sampling
      if (msr_wr && msr_index == IDX_OP_CONTROL) begin
         max_hi_next = msr_wdata[CTL_MAX_LSB +: MAX_HI_W];
         enable_next = msr_wdata[CTL_ENABLE];
         if (state_reg == SEL_HOLD && !msr_wdata[CTL_VALID]) begin
            valid_next = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads; record reads as zero until a retired sample is held
   always_comb begin
      rdata_next = '0;
      ack_next   = msr_rd;
      if (msr_rd) begin
         unique case (msr_index)
            IDX_OP_CONTROL: begin
               rdata_next[CTL_MAX_LSB +: MAX_HI_W] = max_hi_reg;
               rdata_next[CTL_ENABLE]              = enable_reg;
               rdata_next[CTL_VALID]               = valid_reg;
            end
            IDX_BRANCH_OUTCOME: begin
               if (valid_reg) begin
                  rdata_next[BR_COMP_LSB +: TALLY_W]  = comp_cycles;
                  rdata_next[BR_TAG_LSB +: TALLY_W]   = tag_cycles;
                  rdata_next[BR_FLAG_LSB +: BR_FLAG_W] = br_reg;
               end
            end
            IDX_MEMORY_ACCESS: begin
               if (valid_reg) begin
                  rdata_next[MEM_FLAG_W-1:0]      = mem_reg;
                  rdata_next[MEM_LIN_VALID]       = lin_valid_reg;
                  rdata_next[MEM_PHYS_VALID]      = phys_valid_reg;
                  rdata_next[MEM_LAT_LSB +: TALLY_W] = miss_cycles;
               end
            end
            IDX_LINEAR_ADDRESS: begin
               if (valid_reg) begin
                  rdata_next = lin_addr_reg;
               end
            end
            IDX_PHYSICAL_ADDR: begin
               if (valid_reg) begin
                  rdata_next = phys_addr_reg;
               end
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg      <= SEL_COUNT;
         sel_count_reg  <= '0;
         max_hi_reg     <= MAX_HI_RESET;
         enable_reg     <= 1'b0;
         valid_reg      <= 1'b0;
         seed_reg       <= SEED_RESET;
         br_reg         <= '0;
         mem_reg        <= '0;
         lin_valid_reg  <= 1'b0;
         phys_valid_reg <= 1'b0;
         lin_addr_reg   <= '0;
         phys_addr_reg  <= '0;
         completed_reg  <= 1'b0;
         miss_open_reg  <= 1'b0;
         tag_req_reg    <= 1'b0;
         kill_reg       <= 1'b0;
         redirect_reg   <= 1'b0;
         flush_reg      <= 1'b0;
         irq_reg        <= 1'b0;
         rdata_reg      <= '0;
         ack_reg        <= 1'b0;
      end else begin
         state_reg      <= state_next;
         sel_count_reg  <= sel_count_next;
         max_hi_reg     <= max_hi_next;
         enable_reg     <= enable_next;
         valid_reg      <= valid_next;
         seed_reg       <= seed_next;
         br_reg         <= br_next;
         mem_reg        <= mem_next;
         lin_valid_reg  <= lin_valid_next;
         phys_valid_reg <= phys_valid_next;
         lin_addr_reg   <= lin_addr_next;
         phys_addr_reg  <= phys_addr_next;
         completed_reg  <= completed_next;
         miss_open_reg  <= miss_open_next;
         tag_req_reg    <= tag_req_next;
         kill_reg       <= kill_next;
         redirect_reg   <= redirect_next;
         flush_reg      <= flush_next;
         irq_reg        <= irq_next;
         rdata_reg      <= rdata_next;
         ack_reg        <= ack_next;
      end
   end

   assign tag_request    = tag_req_reg;
   assign kill_younger   = kill_reg;
   assign fetch_redirect = redirect_reg;
   assign full_flush     = flush_reg;
   assign sample_irq     = irq_reg;
   assign msr_rdata      = rdata_reg;
   assign msr_ack        = ack_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   record_clear_a: assert property (take_tag |=> br_reg == '0 && mem_reg == '0 && !phys_valid_reg)
      else $error("record not cleared at tag");
   flush_drop_a: assert property (in_flight && op_flush |=> state_reg == SEL_COUNT && !valid_reg)
      else $error("flushed op left a record");
   retire_irq_a: assert property (retire_now && !op_flush |=> sample_irq && valid_reg ##1 !sample_irq)
      else $error("interrupt not one pulse after retire");
   mispredict_kill_a: assert property (retire_now && !op_flush && ret_branch && ret_mispredict && !ret_resync
      |=> kill_younger && fetch_redirect)
      else $error("no kill after mispredicted branch");
   resync_flush_a: assert property (retire_now && !op_flush && ret_resync |=> full_flush && br_reg[BR_RESYNC])
      else $error("resync did not flush");
   branch_mask_a: assert property (retire_now && !op_flush && !ret_branch
      |=> !br_reg[BR_MISP] && !br_reg[BR_TAKEN] && !br_reg[BR_RETIRED])
      else $error("branch flags set for non-branch");
   phys_direct_a: assert property (in_flight && !op_flush && ls_valid && ls_flags[MEM_LOAD] && ls_phys_direct
      && !lin_valid_reg |=> phys_valid_reg && !lin_valid_reg)
      else $error("linear valid set on physical access");
   select_tag_a: assert property (state_reg == SEL_COUNT && enable_reg && sel_count_reg == sel_max
      |=> tag_request && state_reg == SEL_TAG_WAIT)
      else $error("no tag at maximum count");
   tally_run_a: assert property (in_flight && !op_retire && !op_flush ##1 in_flight
      |-> tag_cycles == $past(tag_cycles) + 16'h0001 || &$past(tag_cycles))
      else $error("tag-to-retire count stalled");

endmodule
`default_nettype wire

// ===== hdl/op_sample_pkg.sv
package op_sample_pkg;

   localparam int SEL_W   = 20;
   localparam int MAX_HI_W = 16;
   localparam int TALLY_W = 16;
   localparam int SEED_W  = 7;
   localparam int MSR_IDX_W = 8;

   // Register indices on the model-specific register port
   localparam logic [7:0] IDX_OP_CONTROL      = 8'h00;
   localparam logic [7:0] IDX_BRANCH_OUTCOME  = 8'h01;
   localparam logic [7:0] IDX_MEMORY_ACCESS   = 8'h02;
   localparam logic [7:0] IDX_LINEAR_ADDRESS  = 8'h03;
   localparam logic [7:0] IDX_PHYSICAL_ADDR   = 8'h04;

   // op_control fields
   localparam int CTL_MAX_LSB   = 0;
   localparam int CTL_ENABLE    = 17;
   localparam int CTL_VALID     = 18;
   localparam logic [15:0] MAX_HI_RESET = 16'h0000;

   // op_branch_outcome fields
   localparam int BR_COMP_LSB   = 0;
   localparam int BR_TAG_LSB    = 16;
   localparam int BR_FLAG_LSB   = 32;
   localparam int BR_RETIRED    = 0;
   localparam int BR_MISP       = 1;
   localparam int BR_TAKEN      = 2;
   localparam int BR_RETURN     = 3;
   localparam int BR_RET_MISP   = 4;
   localparam int BR_RESYNC     = 5;
   localparam int BR_FLAG_W     = 6;

   // op_memory_access_info fields
   localparam int MEM_LOAD      = 0;
   localparam int MEM_STORE     = 1;
   localparam int MEM_L1TLB_MISS = 2;
   localparam int MEM_L2TLB_MISS = 3;
   localparam int MEM_L1HIT_2M  = 4;
   localparam int MEM_L1HIT_1G  = 5;
   localparam int MEM_L2HIT_2M  = 6;
   localparam int MEM_DC_MISS   = 7;
   localparam int MEM_MISALIGN  = 8;
   localparam int MEM_BNK_LD    = 9;
   localparam int MEM_BNK_ST    = 10;
   localparam int MEM_FWD       = 11;
   localparam int MEM_FWD_CAN   = 12;
   localparam int MEM_UC        = 13;
   localparam int MEM_WC        = 14;
   localparam int MEM_LOCKED    = 15;
   localparam int MEM_MAB_HIT   = 16;
   localparam int MEM_FLAG_W    = 17;
   localparam int MEM_LIN_VALID = 17;
   localparam int MEM_PHYS_VALID = 18;
   localparam int MEM_LAT_LSB   = 32;

   localparam logic [6:0] SEED_RESET = 7'h5A;

   typedef enum logic [1:0] {
      SEL_COUNT,
      SEL_TAG_WAIT,
      SEL_IN_FLIGHT,
      SEL_HOLD
   } sample_state_e;

endpackage

// ===== hdl/cycle_tally.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_tally
   import op_sample_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               clear,
   input  wire logic               run,
   output logic [TALLY_W-1:0]      count
);

   logic [TALLY_W-1:0] count_reg;
   logic [TALLY_W-1:0] count_next;

   // Saturates so a long wait never wraps to a small value
   always_comb begin
      count_next = count_reg;
      if (clear) begin
         count_next = '0;
      end else if (run && count_reg != {TALLY_W{1'b1}}) begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

endmodule
`default_nettype wire

// ===== bench/core_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_pipe_model
   import op_sample_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  tag_request,
   input  wire logic                  go,
   input  wire logic [3:0]            slow,
   input  wire logic                  flush_it,
   input  wire logic [5:0]            rv,
   input  wire logic [MEM_FLAG_W-1:0] mem,
   input  wire logic                  direct,
   input  wire logic [63:0]           addr,
   output logic                       idle,
   output logic                       op_tagged,
   output logic                       op_complete,
   output logic                       op_retire,
   output logic                       op_flush,
   output logic [5:0]                 ret_flags,
   output logic                       ls_valid,
   output logic [MEM_FLAG_W-1:0]      ls_flags,
   output logic                       ls_phys_direct,
   output logic [63:0]                ls_linear_addr,
   output logic [63:0]                ls_physical_addr,
   output logic                       dc_miss_detect,
   output logic                       dc_data_deliver
);
   initial begin
      {idle, op_tagged, op_complete, op_retire, op_flush, ls_valid, dc_miss_detect, dc_data_deliver} = 8'h80;
      {ret_flags, ls_flags, ls_phys_direct, ls_linear_addr, ls_physical_addr} = '0;
      forever begin
         @(posedge ref_clk);
         if (go) begin
            idle = 0;
            for (int w = 0; w < 3000 && tag_request !== 1'b1; w++) @(posedge ref_clk);
            repeat (slow) @(posedge ref_clk);
            #1 op_tagged = 1;
            @(posedge ref_clk) #1 op_tagged = 0;
            ls_valid = |mem[1:0];
            {ls_flags, ls_phys_direct, ls_linear_addr, ls_physical_addr} = {mem, direct, addr, ~addr};
            dc_miss_detect = mem[MEM_DC_MISS] & ls_valid;
            @(posedge ref_clk) #1 {ls_valid, dc_miss_detect, op_complete} = 3'b001;
            // Stale lines after release
            {ls_flags, ls_phys_direct, ls_linear_addr} = ~{ls_flags, ls_phys_direct, ls_linear_addr};
            @(posedge ref_clk) #1 op_complete = 0;
            @(posedge ref_clk) #1 dc_data_deliver = mem[MEM_DC_MISS] & |mem[1:0];
            @(posedge ref_clk) #1 {dc_data_deliver, op_retire, op_flush, ret_flags} = {1'b0, !flush_it, flush_it, rv};
            @(posedge ref_clk) #1 {op_retire, op_flush} = 2'b00;
            ret_flags = ~rv;
            idle = 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/op_sample_event_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
module op_sample_event_capture_tb;
   import op_sample_pkg::*;
   logic                  ref_clk = 0, rst = 1, msr_rd = 0, msr_wr = 0, go = 0, flush_it = 0, direct = 0;
   logic [7:0]            msr_index = '0;
   logic [63:0]           msr_wdata = '0, addr = '0, msr_rdata, rd_val, ls_linear_addr, ls_physical_addr;
   logic [5:0]            rv = '0, ret_flags;
   logic [3:0]            slow = '0;
   logic [MEM_FLAG_W-1:0] mem = '0, ls_flags;
   logic                  tag_request, op_tagged, op_complete, op_retire, op_flush, ls_valid, ls_phys_direct;
   logic                  dc_miss_detect, dc_data_deliver, msr_ack, kill_younger, fetch_redirect, full_flush;
   logic                  sample_irq, idle;
   int                    mismatches = 0, tests_run = 0, n_irq = 0, n_kill = 0, n_redir = 0, n_full = 0, lat;

   always #12.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      n_irq += sample_irq;
      n_kill += kill_younger;
      n_redir += fetch_redirect;
      n_full += full_flush;
   end

   op_sample_event_capture dut (
      .ref_clk, .rst, .msr_rd, .msr_wr, .msr_index, .msr_wdata, .msr_rdata, .msr_ack, .tag_request, .op_tagged,
      .op_complete, .op_retire, .op_flush, .ret_branch(ret_flags[0]), .ret_mispredict(ret_flags[1]),
      .ret_taken(ret_flags[2]), .ret_return(ret_flags[3]), .ret_return_misp(ret_flags[4]), .ret_resync(ret_flags[5]),
      .ls_valid, .ls_flags, .ls_phys_direct, .ls_linear_addr, .ls_physical_addr, .dc_miss_detect, .dc_data_deliver,
      .kill_younger, .fetch_redirect, .full_flush, .sample_irq
   );
   core_pipe_model pipe (
      .ref_clk, .tag_request, .go, .slow, .flush_it, .rv, .mem, .direct, .addr, .idle, .op_tagged, .op_complete,
      .op_retire, .op_flush, .ret_flags, .ls_valid, .ls_flags, .ls_phys_direct, .ls_linear_addr, .ls_physical_addr,
      .dc_miss_detect, .dc_data_deliver
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic msr_write(input logic [7:0] idx, input logic [63:0] d);
      @(posedge ref_clk) #1 {msr_wr, msr_index, msr_wdata} = {1'b1, idx, d};
      @(posedge ref_clk) #1 msr_wr = 0;
   endtask
   task automatic msr_read(input logic [7:0] idx);
      @(posedge ref_clk) #1 {msr_rd, msr_index} = {1'b1, idx};
      @(posedge ref_clk) #1 msr_rd = 0;
      chk(msr_ack, 1, "read ack");
      rd_val = msr_rdata;
   endtask
   task automatic sample(input logic [15:0] mx, input logic [5:0] r, input logic fl, input logic [16:0] m,
                         input logic d, input logic [3:0] s);
      int q0, k0, r0, f0;
      logic kl, fu, ls;
      msr_write(IDX_OP_CONTROL, {45'h0, 3'b010, mx});
      lat = 0;
      do begin
         @(posedge ref_clk) lat++;
      end while (tag_request !== 1'b1 && lat < 3000);
      chk(tag_request, 1, "tag request");
      #1 {rv, flush_it, mem, direct, slow, addr} = {r, fl, m, d, s, {4{m[15:0]}}};
      {q0, k0, r0, f0} = {n_irq, n_kill, n_redir, n_full};
      go = 1;
      @(posedge ref_clk) #1 go = 0;
      for (int i = 0; i < 3000 && idle !== 1'b1; i++) @(posedge ref_clk);
      chk(idle, 1, "pipeline finished");
      repeat (2) @(posedge ref_clk);
      kl = r[0] & r[1] & !r[5] & !fl;
      fu = r[5] & !fl;
      ls = |m[1:0] & !fl;
      chk(n_irq - q0, !fl, "interrupt");
      chk(n_kill - k0, kl, "kill younger");
      chk(n_redir - r0, kl | fu, "redirect");
      chk(n_full - f0, fu, "full flush");
      msr_read(IDX_OP_CONTROL);
      chk(rd_val, {45'h0, !fl, 2'b10, mx}, "control");
      msr_read(IDX_BRANCH_OUTCOME);
      chk(rd_val, fl ? 64'h0 : {26'h0, r[5], r[4] & r[3], r[3], r[2] & r[0], r[1] & r[0], r[0], 16'd4, 16'd2},
          "branch outcome");
      msr_read(IDX_MEMORY_ACCESS);
      chk(rd_val, !ls ? 64'h0 : {16'h0, (m[0] & m[7]) ? 16'd3 : 16'd0, 13'h0, 1'b1, !d, m},
          "memory access");
      msr_read(IDX_PHYSICAL_ADDR);
      chk(rd_val, ls ? ~addr : 64'h0, "physical address");
      msr_read(IDX_LINEAR_ADDRESS);
      chk(rd_val, (ls && !d) ? addr : 64'h0, "linear address");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic reset_regs;
      chk(tag_request, 0, "idle tag request");
      msr_read(8'h07);
      chk(rd_val, 0, "unmapped");
      msr_read(IDX_OP_CONTROL);
      chk(rd_val, 0, "control reset");
   endtask
   task automatic memory_ops;
      sample(16'h1, 6'h00, 0, 17'h1FFFD, 1, 4'd0);
      sample(16'h1, 6'h00, 0, 17'h00082, 0, 4'd2);
      sample(16'h1, 6'h00, 0, 17'h00003, 0, 4'd1);
   endtask
   task automatic tag_timing;
      int l1;
      sample(16'h1, 6'h00, 0, '0, 0, 4'd0);
      l1 = lat;
      sample(16'h2, 6'h00, 0, '0, 0, 4'd3);
      chk(lat - l1, 16, "selection spacing");
   endtask
   task automatic branch_table;
      logic [5:0] tbl [9] = '{6'h01, 6'h05, 6'h03, 6'h07, 6'h1F, 6'h0D, 6'h06, 6'h25, 6'h10};
      foreach (tbl[i]) sample(16'h1, tbl[i], 0, '0, 0, 4'(i % 3));
   endtask
   task automatic flushed_op;
      sample(16'h1, 6'h07, 1, 17'h00081, 0, 4'd1);
      sample(16'h10, 6'h03, 0, '0, 0, 4'd0);
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      #1 rst = 0;
      reset_regs;
      memory_ops;
      tag_timing;
      branch_table;
      flushed_op;
      stop_test;
   end
   initial begin
      #500000;
      mismatches++;
      stop_test;
   end
endmodule
`default_nettype wire
